// File: common/esc_pkg.sv
// Operation
// - Start edge begins counting, gate edge stops
// - Further start edges ignored while counting
// - Stopping gate edge pushes count into FIFO in single and implicit forms
// - Start and gate polarity independently selectable
// - Counted source edge rising or falling
// - Single form idles after one result until rearm
// - Implicit form restarts at next gate edge
// - Sample-clocked form stores only on sample edge
// - Timed single point equals sample-clocked form
// - Overrun when gate or start missing between samples
// - Single pulse after delay counted in source edges
// - Pulse high width counted in source edges
// - Triggered pulse: delay from gate, then gate ignored
// - Embedded counter ends finite train at count
// - Compatibility train gated by paired counter pulse
// - Fixed pairing, gating taken from the synchronised pairGate pin
// - Retriggerable: each trigger after a generation ends launches a new generation
// - Delay on every retrigger or first only
// - Gate ignored during generation, then await trigger
// - At least two source ticks after trigger
package esc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DELAY = 8'h04;
   localparam logic [7:0] ADDR_HIGH = 8'h08;
   localparam logic [7:0] ADDR_LOW = 8'h0c;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_FIFO = 8'h18;
   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int CTRL_ARM = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_MODE_LO = 4;
   localparam int CTRL_MODE_HI = 6;
   localparam int CTRL_SRC_FALL = 8;
   localparam int CTRL_START_FALL = 9;
   localparam int CTRL_GATE_FALL = 10;
   localparam int CTRL_TRIG_EN = 11;
   localparam int CTRL_RETRIG = 12;
   localparam int CTRL_DLY_OVR = 13;
   localparam int CTRL_DLY_EVERY = 14;
   localparam int CTRL_COMPAT = 15;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_KEEP_MASK = 32'h0000_fff0;
   // ----------------------------------------
   // Status fields
   // ----------------------------------------
   localparam int STAT_MEAS_BUSY = 0;
   localparam int STAT_GEN_BUSY = 1;
   localparam int STAT_DONE = 2;
   localparam int STAT_OVERRUN = 3;
   localparam int STAT_EMPTY = 4;
   localparam int STAT_FULL = 5;
   localparam int STAT_OUT = 6;
   // ----------------------------------------
   // Modes and constants
   // ----------------------------------------
   localparam logic [2:0] MODE_SINGLE = 3'h0;
   localparam logic [2:0] MODE_IMPLICIT = 3'h1;
   localparam logic [2:0] MODE_SAMPLED = 3'h2;
   localparam logic [2:0] MODE_TIMED_SINGLE_POINT = 3'h3;
   localparam logic [2:0] MODE_PULSE = 3'h4;
   localparam logic [2:0] MODE_TRAIN = 3'h5;
   localparam int FIFO_DEPTH = 4;
   localparam int FIFO_AW = 2;
   localparam logic [31:0] MIN_TRIG_TICKS = 32'h0000_0002;
   localparam logic [31:0] ONE = 32'h0000_0001;
   localparam int SYNC_W = 5;
   typedef enum logic [2:0] {MeasIdle, MeasWaitStart, MeasCount, MeasRearm, MeasDone} esc_meas_state_type;
   typedef enum logic [2:0] {GenIdle, GenWaitTrig, GenDelay, GenHigh, GenLow, GenDone} esc_gen_state_type;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } esc_apb_req_type;
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } esc_apb_rsp_type;
   typedef struct packed {
      logic src;
      logic start;
      logic gate;
      logic sampleClk;
      logic pairGate;
   } esc_pins_type;
endpackage

// File: hdl/esc_counter.sv
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module esc_counter (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire esc_pkg::esc_apb_req_type apbReq,
   output esc_pkg::esc_apb_rsp_type apbRsp,
   input wire esc_pkg::esc_pins_type pins,
   output logic ctrOut,
   output logic [31:0] dmaData,
   output logic dmaValid,
   input wire logic dmaReady
);
   import esc_pkg::*;

   // ----------------------------------------
   // Pin synchronisers and edge detect
   // ----------------------------------------
   logic [SYNC_W-1:0] syncA_q, syncB_q, prev_q;
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         syncA_q <= '0;
         syncB_q <= '0;
         prev_q <= '0;
      end else if (clkEn) begin
         syncA_q <= pins;
         syncB_q <= syncA_q;
         prev_q <= syncB_q;
      end
   end

   logic [31:0] ctrl_q, delay_q, high_q, low_q, count_q;
   logic srcEdge, startEdge, gateEdge, sampleEdge, pairGate;
   logic [SYNC_W-1:0] rise, fall;
   assign rise = syncB_q & ~prev_q;
   assign fall = ~syncB_q & prev_q;
   // Bit order follows esc_pins_type: src, start, gate, sampleClk, pairGate
   assign srcEdge = ctrl_q[CTRL_SRC_FALL] ? fall[4] : rise[4];
   assign startEdge = ctrl_q[CTRL_START_FALL] ? fall[3] : rise[3];
   assign gateEdge = ctrl_q[CTRL_GATE_FALL] ? fall[2] : rise[2];
   assign sampleEdge = rise[1];
   assign pairGate = syncB_q[0];

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic setup, wrAcc, rdAcc, armPulse, stopPulse, fifoPopBus;
   logic [2:0] mode;
   logic isMeas, isSampled;
   assign setup = apbReq.psel && !apbReq.penable;
   assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite && clkEn;
   assign rdAcc = apbReq.psel && apbReq.penable && !apbReq.pwrite && clkEn;
   assign armPulse = wrAcc && apbReq.paddr == ADDR_CTRL && apbReq.pwdata[CTRL_ARM];
   assign stopPulse = wrAcc && apbReq.paddr == ADDR_CTRL && apbReq.pwdata[CTRL_STOP];
   assign fifoPopBus = rdAcc && apbReq.paddr == ADDR_FIFO;
   assign mode = ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO];
   assign isMeas = mode < MODE_PULSE;
   assign isSampled = mode == MODE_SAMPLED || mode == MODE_TIMED_SINGLE_POINT;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RESET;
         delay_q <= '0;
         high_q <= ONE;
         low_q <= ONE;
         count_q <= ONE;
      end else if (wrAcc) begin
         case (apbReq.paddr)
            ADDR_CTRL: ctrl_q <= apbReq.pwdata & CTRL_KEEP_MASK;
            ADDR_DELAY: delay_q <= apbReq.pwdata;
            ADDR_HIGH: high_q <= apbReq.pwdata;
            ADDR_LOW: low_q <= apbReq.pwdata;
            ADDR_COUNT: count_q <= apbReq.pwdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Result FIFO
   // ----------------------------------------
   logic [31:0] fifoMem_q [FIFO_DEPTH];
   logic [FIFO_AW:0] wrPtr_q, rdPtr_q;
   logic fifoEmpty, fifoFull, push, pop;
   logic [31:0] pushData;
   assign fifoEmpty = wrPtr_q == rdPtr_q;
   assign fifoFull = wrPtr_q[FIFO_AW] != rdPtr_q[FIFO_AW] && wrPtr_q[FIFO_AW-1:0] == rdPtr_q[FIFO_AW-1:0];
   assign dmaValid = !fifoEmpty;
   assign dmaData = fifoMem_q[rdPtr_q[FIFO_AW-1:0]];
   // Bus read and DMA share the head; a bus pop also satisfies a DMA handshake
   assign pop = !fifoEmpty && clkEn && (fifoPopBus || dmaReady);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else if (clkEn) begin
         if (push && !fifoFull) begin
            fifoMem_q[wrPtr_q[FIFO_AW-1:0]] <= pushData;
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         if (armPulse) begin
            rdPtr_q <= wrPtr_q;
         end
      end
   end

   // ----------------------------------------
   // Edge-separation measurement
   // ----------------------------------------
   esc_meas_state_type meas_q;
   logic [31:0] runCnt_q, held_q;
   logic heldValid_q, seenGate_q, seenStart_q, overrun_q, done_q;
   logic stopNow;
   assign stopNow = meas_q == MeasCount && gateEdge;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meas_q <= MeasIdle;
      end else if (clkEn) begin
         if (stopPulse || (armPulse && apbReq.pwdata[CTRL_MODE_HI:CTRL_MODE_LO] >= MODE_PULSE)) begin
            meas_q <= MeasIdle;
         end else if (armPulse) begin
            meas_q <= MeasWaitStart;
         end else begin
            case (meas_q)
               MeasIdle: ;
               MeasWaitStart: if (startEdge) meas_q <= MeasCount;
               MeasCount: if (gateEdge) begin
                  if (mode == MODE_SINGLE) begin
                     meas_q <= MeasDone;
                  end else begin
                     meas_q <= MeasRearm;
                  end
               end
               MeasRearm: if (gateEdge) meas_q <= MeasCount;
               MeasDone: ;
               default: meas_q <= MeasIdle;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         runCnt_q <= '0;
      end else if (clkEn) begin
         if ((meas_q == MeasWaitStart && startEdge) || (meas_q == MeasRearm && gateEdge)) begin
            runCnt_q <= '0;
         end else if (meas_q == MeasCount && srcEdge) begin
            runCnt_q <= runCnt_q + ONE;
         end
      end
   end

   // Sample-clocked forms park the result until the next sample edge
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         held_q <= '0;
         heldValid_q <= 1'b0;
      end else if (clkEn) begin
         if (armPulse) begin
            heldValid_q <= 1'b0;
         end else if (stopNow && isSampled) begin
            held_q <= runCnt_q;
            heldValid_q <= 1'b1;
         end else if (sampleEdge) begin
            heldValid_q <= 1'b0;
         end
      end
   end

   always_comb begin
      push = 1'b0;
      pushData = runCnt_q;
      if (isMeas && isSampled) begin
         push = sampleEdge && heldValid_q;
         pushData = held_q;
      end else if (isMeas) begin
         push = stopNow;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         seenGate_q <= 1'b0;
         seenStart_q <= 1'b0;
      end else if (clkEn) begin
         if (armPulse || sampleEdge) begin
            seenGate_q <= gateEdge;
            seenStart_q <= startEdge;
         end else begin
            seenGate_q <= seenGate_q | gateEdge;
            seenStart_q <= seenStart_q | startEdge;
         end
      end
   end

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         overrun_q <= 1'b0;
      end else if (clkEn) begin
         if ((isSampled && meas_q != MeasIdle && sampleEdge && !(seenGate_q && seenStart_q))
             || (push && fifoFull)) begin
            overrun_q <= 1'b1;
         end else if (wrAcc && apbReq.paddr == ADDR_STATUS && apbReq.pwdata[STAT_OVERRUN]) begin
            overrun_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Pulse generation
   // ----------------------------------------
   esc_gen_state_type gen_q;
   logic [31:0] tick_q, pulses_q, effDelay, waitTgt;
   logic firstTrig_q, out_q, delayEvery, finishNow, lastHigh;
   // Short delays are stretched so a trigger never meets its first edge too early
   assign effDelay = delay_q < MIN_TRIG_TICKS ? MIN_TRIG_TICKS : delay_q;
   assign delayEvery = ctrl_q[CTRL_DLY_OVR] ? ctrl_q[CTRL_DLY_EVERY] : mode == MODE_PULSE;
   assign waitTgt = (firstTrig_q || delayEvery) ? effDelay : MIN_TRIG_TICKS;
   assign lastHigh = mode == MODE_PULSE
                     || (ctrl_q[CTRL_COMPAT] ? !pairGate : pulses_q + ONE >= count_q);
   assign finishNow = gen_q == GenHigh && srcEdge && tick_q + ONE >= high_q && lastHigh;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         gen_q <= GenIdle;
         tick_q <= '0;
         pulses_q <= '0;
         firstTrig_q <= 1'b1;
      end else if (clkEn) begin
         if (stopPulse || (armPulse && apbReq.pwdata[CTRL_MODE_HI:CTRL_MODE_LO] < MODE_PULSE)) begin
            gen_q <= GenIdle;
         end else if (armPulse) begin
            tick_q <= '0;
            pulses_q <= '0;
            firstTrig_q <= 1'b1;
            gen_q <= apbReq.pwdata[CTRL_TRIG_EN] ? GenWaitTrig : GenDelay;
         end else begin
            case (gen_q)
               GenIdle: ;
               GenWaitTrig: if (gateEdge) begin
                  tick_q <= '0;
                  pulses_q <= '0;
                  gen_q <= GenDelay;
               end
               GenDelay: if (srcEdge) begin
                  tick_q <= tick_q + ONE;
                  if (tick_q + ONE >= (ctrl_q[CTRL_TRIG_EN] ? waitTgt : delay_q)) begin
                     tick_q <= '0;
                     gen_q <= GenHigh;
                  end
               end
               GenHigh: if (srcEdge) begin
                  tick_q <= tick_q + ONE;
                  if (tick_q + ONE >= high_q) begin
                     tick_q <= '0;
                     pulses_q <= pulses_q + ONE;
                     if (finishNow) begin
                        firstTrig_q <= 1'b0;
                        // Gate is only looked at again once the generation ends
                        gen_q <= (ctrl_q[CTRL_TRIG_EN] && ctrl_q[CTRL_RETRIG]) ? GenWaitTrig : GenDone;
                     end else begin
                        gen_q <= GenLow;
                     end
                  end
               end
               GenLow: if (srcEdge) begin
                  tick_q <= tick_q + ONE;
                  if (tick_q + ONE >= low_q) begin
                     tick_q <= '0;
                     gen_q <= GenHigh;
                  end
               end
               GenDone: ;
               default: gen_q <= GenIdle;
            endcase
         end
      end
   end

   // Output registered; the low width before a retrigger is not enforced
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         out_q <= 1'b0;
      end else if (clkEn) begin
         out_q <= gen_q == GenHigh && !(srcEdge && tick_q + ONE >= high_q)
                  || (gen_q != GenHigh && gen_q != GenIdle && !stopPulse && !armPulse && srcEdge
                      && ((gen_q == GenDelay && tick_q + ONE >= (ctrl_q[CTRL_TRIG_EN] ? waitTgt : delay_q))
                          || (gen_q == GenLow && tick_q + ONE >= low_q)));
      end
   end
   assign ctrOut = out_q;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         done_q <= 1'b0;
      end else if (clkEn) begin
         if (armPulse) begin
            done_q <= 1'b0;
         end else if (meas_q == MeasDone || gen_q == GenDone) begin
            done_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [31:0] rdData_q, status;
   logic err_q;
   always_comb begin
      status = '0;
      status[STAT_MEAS_BUSY] = meas_q != MeasIdle && meas_q != MeasDone;
      status[STAT_GEN_BUSY] = gen_q != GenIdle && gen_q != GenDone;
      status[STAT_DONE] = done_q;
      status[STAT_OVERRUN] = overrun_q;
      status[STAT_EMPTY] = fifoEmpty;
      status[STAT_FULL] = fifoFull;
      status[STAT_OUT] = out_q;
   end

   // Loaded at setup even when frozen; a stalled read must still return it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rdData_q <= '0;
         err_q <= 1'b0;
      end else if (setup) begin
         err_q <= 1'b0;
         case (apbReq.paddr)
            ADDR_CTRL: rdData_q <= ctrl_q;
            ADDR_DELAY: rdData_q <= delay_q;
            ADDR_HIGH: rdData_q <= high_q;
            ADDR_LOW: rdData_q <= low_q;
            ADDR_COUNT: rdData_q <= count_q;
            ADDR_STATUS: rdData_q <= status;
            ADDR_FIFO: rdData_q <= fifoEmpty ? '0 : dmaData;
            default: begin
               rdData_q <= '0;
               err_q <= 1'b1;
            end
         endcase
      end
   end
   assign apbRsp.pready = clkEn;
   assign apbRsp.pslverr = err_q;
   assign apbRsp.prdata = rdData_q;
endmodule // esc_counter
`default_nettype wire

// File: bench/esc_counter_properties.sv
`timescale 1ns/1ps
`default_nettype none
module esc_counter_properties (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire esc_pkg::esc_apb_req_type apbReq,
   input wire esc_pkg::esc_apb_rsp_type apbRsp,
   input wire esc_pkg::esc_pins_type pins,
   input wire logic ctrOut,
   input wire logic [31:0] dmaData,
   input wire logic dmaValid,
   input wire logic dmaReady
);
   import esc_pkg::*;
   // ---
   // Helpers
   // ---
   logic armSeen_q;
   logic srcPrev_q;
   logic gatePrev_q;
   logic [3:0] sinceSrc_q;
   logic [3:0] sinceGate_q;
   logic [1:0] srcAfterGate_q;
   // Saturating counters: ages of the last raw pin changes, and source changes since the last gate change
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         armSeen_q <= 1'b0;
         srcPrev_q <= 1'b0;
         gatePrev_q <= 1'b0;
         sinceSrc_q <= 4'hf;
         sinceGate_q <= 4'hf;
         srcAfterGate_q <= 2'h3;
      end else begin
         srcPrev_q <= pins.src;
         gatePrev_q <= pins.gate;
         if (apbReq.psel && apbReq.penable && apbReq.pwrite && clkEn && apbReq.paddr == ADDR_CTRL
             && apbReq.pwdata[CTRL_ARM]) begin
            armSeen_q <= 1'b1;
         end
         sinceSrc_q <= (pins.src != srcPrev_q) ? 4'h0 : sinceSrc_q + {3'h0, sinceSrc_q != 4'hf};
         sinceGate_q <= (pins.gate != gatePrev_q) ? 4'h0 : sinceGate_q + {3'h0, sinceGate_q != 4'hf};
         if (pins.gate != gatePrev_q) begin
            srcAfterGate_q <= 2'h0;
         end else if (pins.src != srcPrev_q && srcAfterGate_q != 2'h3) begin
            srcAfterGate_q <= srcAfterGate_q + 2'h1;
         end
      end
   end
   // ---
   // Properties
   // ---
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   armed_first_a: assert property (!armSeen_q |-> !dmaValid && !ctrOut)
      else $error("output before arming");
   unmapped_err_a: assert property (apbReq.psel && !apbReq.penable && clkEn && apbReq.paddr > ADDR_FIFO
      |=> apbRsp.pslverr && apbRsp.prdata == 32'h0) else $error("unmapped access not refused");
   push_on_gate_a: assert property ($rose(dmaValid) |-> sinceGate_q <= 4'h8
      || (pins.sampleClk && !$past(pins.sampleClk, 4)))
      else $error("result without gate edge");
   head_hold_a: assert property (dmaValid && !dmaReady && !apbReq.psel && clkEn |=> $stable(dmaData))
      else $error("fifo head changed while stalled");
   rise_on_src_a: assert property ($rose(ctrOut) |-> sinceSrc_q <= 4'h6)
      else $error("pulse rose without source edge");
   fall_on_src_a: assert property ($fell(ctrOut) |-> sinceSrc_q <= 4'h6 || $past(apbReq.psel))
      else $error("pulse fell without source edge");
   trig_gap_a: assert property ($rose(ctrOut) |-> srcAfterGate_q >= 2'h2)
      else $error("pulse too soon after trigger");
   frozen_hold_a: assert property (!clkEn |=> $stable(ctrOut) && $stable(dmaValid))
      else $error("state moved while clock disabled");
endmodule // esc_counter_properties
bind esc_counter esc_counter_properties chk_u (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .apbReq(apbReq),
   .apbRsp(apbRsp), .pins(pins), .ctrOut(ctrOut), .dmaData(dmaData), .dmaValid(dmaValid), .dmaReady(dmaReady));
`default_nettype wire

// File: bench/esc_pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module esc_pin_source (
   input wire logic sys_clk,
   output var esc_pkg::esc_pins_type pins
);
   import esc_pkg::*;
   localparam int HALF = 4;
   initial pins = '0;
   // Gate serves as stop edge or start trigger, never pause; wait covers the sync delay
   task automatic set_levels(input logic st, input logic gt);
      @(posedge sys_clk);
      pins.start <= st;
      pins.gate <= gt;
      repeat (8) @(posedge sys_clk);
   endtask
   // Timebase stands low between bursts
   task automatic run_src(input int n);
      repeat (2 * n) begin
         repeat (HALF) @(posedge sys_clk);
         pins.src <= ~pins.src;
      end
      repeat (8) @(posedge sys_clk);
   endtask
   // Sample clock and paired gate levels; only rising sample edges count
   task automatic set_aux(input logic sc, input logic pg);
      @(posedge sys_clk);
      pins.sampleClk <= sc;
      pins.pairGate <= pg;
      repeat (8) @(posedge sys_clk);
   endtask
endmodule // esc_pin_source
`default_nettype wire

// File: bench/esc_counter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module esc_counter_tb_top;
   import esc_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst, clkEn, dmaReady, ctrOut, dmaValid, srcFall, rndEn, rdErr;
   logic ctrPrev, srcPrev, gatePrev;
   logic [31:0] dmaData, lfsr, rd;
   esc_apb_req_type apbReq;
   esc_apb_rsp_type apbRsp;
   esc_pins_type pins;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   int edgeCnt = 0;
   logic [31:0] expQ[$];
   always #5 sys_clk = ~sys_clk;
   esc_counter dut_u (.sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .apbReq(apbReq), .apbRsp(apbRsp),
      .pins(pins), .ctrOut(ctrOut), .dmaData(dmaData), .dmaValid(dmaValid), .dmaReady(dmaReady));
   esc_pin_source src_u (.sys_clk(sys_clk), .pins(pins));
   // ---
   // Helpers
   // ---
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         failures++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask
   task automatic take(input logic [31:0] got, input string what);
      logic ok;
      logic [31:0] exp;
      ok = expQ.size() != 0;
      if (ok) exp = expQ.pop_front();
      check(ok && got === exp, what);
   endtask
   task automatic tally_and_finish;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
      @(posedge sys_clk);
      apbReq.psel <= 1'b1;
      apbReq.penable <= 1'b0;
      apbReq.pwrite <= wr;
      apbReq.paddr <= addr;
      apbReq.pwdata <= data;
      @(posedge sys_clk);
      apbReq.penable <= 1'b1;
      do @(posedge sys_clk); while (apbRsp.pready !== 1'b1);
      rd = apbRsp.prdata;
      rdErr = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic err);
      apb(1'b0, addr, 32'h0);
      check(rd === exp && rdErr === err, "register read");
   endtask
   task automatic drain;
      for (int i = 0; i < 600 && expQ.size() != 0; i++) @(posedge sys_clk);
      check(expQ.size() == 0, "result missing");
   endtask
   // ---
   // Monitor: active source edges between output changes
   // ---
   always @(posedge sys_clk) begin
      cycles++;
      lfsr <= lfsr_next(lfsr);
      dmaReady <= lfsr[2] | lfsr[7];
      clkEn <= rndEn ? (lfsr[0] | lfsr[5]) : 1'b1;
      srcPrev <= pins.src;
      gatePrev <= pins.gate;
      ctrPrev <= ctrOut;
      if (dmaValid === 1'b1 && dmaReady === 1'b1 && clkEn === 1'b1) take(dmaData, "fifo word");
      if (ctrOut !== ctrPrev) begin
         take(edgeCnt, "edge count");
         edgeCnt = 0;
      end else if (pins.src !== srcPrev && pins.src === ~srcFall) edgeCnt++;
      if (pins.gate !== gatePrev) edgeCnt = 0;
      if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1 && apbReq.paddr == ADDR_CTRL) edgeCnt = 0;
      if (cycles > 60000) begin
         failures++;
         tally_and_finish();
      end
   end
   // ---
   // Scenarios
   // ---
   initial begin
      nrst = 1'b0;
      clkEn = 1'b1;
      dmaReady = 1'b0;
      srcFall = 1'b0;
      rndEn = 1'b0;
      lfsr = 32'h04502f05;
      ctrPrev = 1'b0;
      srcPrev = 1'b0;
      gatePrev = 1'b0;
      apbReq = '0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      rndEn <= 1'b1;
      src_u.set_levels(1'b1, 1'b1);
      src_u.run_src(2);
      src_u.set_levels(1'b0, 1'b0);
      rd_chk(ADDR_CTRL, CTRL_RESET, 1'b0);
      rd_chk(ADDR_DELAY, 32'h0, 1'b0);
      rd_chk(ADDR_HIGH, ONE, 1'b0);
      rd_chk(ADDR_LOW, ONE, 1'b0);
      rd_chk(ADDR_COUNT, ONE, 1'b0);
      rd_chk(ADDR_STATUS, ONE << STAT_EMPTY, 1'b0);
      rd_chk(8'h1c, 32'h0, 1'b1);
      check(dmaValid === 1'b0, "result before arming");
      rndEn <= 1'b0;
      // Single measurement over all four start and gate polarities
      for (int i = 0; i < 4; i++) begin
         src_u.set_levels(i[0], i[1]);
         apb(1'b1, ADDR_CTRL, ONE | (32'(i) << CTRL_START_FALL) | (32'(i[0] ^ i[1]) << CTRL_SRC_FALL));
         src_u.set_levels(~i[0], i[1]);
         src_u.run_src(2 + i);
         src_u.set_levels(i[0], i[1]);
         src_u.set_levels(~i[0], i[1]);
         src_u.run_src(3);
         expQ.push_back(32'(5 + i));
         src_u.set_levels(~i[0], ~i[1]);
         src_u.set_levels(i[0], i[1]);
         src_u.run_src(2);
         src_u.set_levels(~i[0], ~i[1]);
         src_u.set_levels(i[0], i[1]);
         drain();
      end
      // Single pulse, both source polarities
      for (int i = 0; i < 2; i++) begin
         srcFall = i[0];
         apb(1'b1, ADDR_DELAY, 32'h4);
         apb(1'b1, ADDR_HIGH, 32'h3);
         expQ.push_back(32'h4);
         expQ.push_back(32'h3);
         apb(1'b1, ADDR_CTRL, ONE | (32'(i) << CTRL_SRC_FALL) | (32'(MODE_PULSE) << CTRL_MODE_LO));
         src_u.run_src(10);
         drain();
      end
      // Triggered pulse: edges before the trigger do not count, second trigger ignored
      srcFall = 1'b0;
      src_u.set_levels(1'b0, 1'b0);
      apb(1'b1, ADDR_DELAY, 32'h3);
      apb(1'b1, ADDR_HIGH, 32'h2);
      expQ.push_back(32'h3);
      expQ.push_back(32'h2);
      apb(1'b1, ADDR_CTRL, ONE | (32'(MODE_PULSE) << CTRL_MODE_LO) | (ONE << CTRL_TRIG_EN));
      src_u.run_src(3);
      src_u.set_levels(1'b0, 1'b1);
      src_u.run_src(6);
      src_u.set_levels(1'b0, 1'b0);
      src_u.set_levels(1'b0, 1'b1);
      src_u.run_src(6);
      drain();
      // Finite train of three pulses, then nothing more
      apb(1'b1, ADDR_DELAY, 32'h2);
      apb(1'b1, ADDR_LOW, 32'h1);
      apb(1'b1, ADDR_COUNT, 32'h3);
      for (int k = 0; k < 6; k++) expQ.push_back((k == 0 || k[0]) ? 32'h2 : 32'h1);
      apb(1'b1, ADDR_CTRL, ONE | (32'(MODE_TRAIN) << CTRL_MODE_LO));
      src_u.run_src(14);
      drain();
      // Retriggered pulses, default delay and delay on first trigger only
      src_u.set_levels(1'b0, 1'b0);
      apb(1'b1, ADDR_DELAY, 32'h3);
      for (int j = 0; j < 2; j++) begin
         expQ.push_back(32'h3);
         expQ.push_back(32'h2);
         expQ.push_back(j ? 32'h2 : 32'h3);
         expQ.push_back(32'h2);
         apb(1'b1, ADDR_CTRL, ONE | (32'(MODE_PULSE) << CTRL_MODE_LO) | (32'h3 << CTRL_TRIG_EN)
             | (32'(j) << CTRL_DLY_OVR));
         for (int t = 0; t < 2; t++) begin
            src_u.set_levels(1'b0, 1'b1);
            src_u.run_src(6);
            src_u.set_levels(1'b0, 1'b0);
         end
         drain();
      end
      // Compatibility train ends at a high end with the paired gate low
      src_u.set_aux(1'b0, 1'b1);
      expQ = {32'h3, 32'h2, 32'h1, 32'h2};
      apb(1'b1, ADDR_CTRL, ONE | (32'(MODE_TRAIN) << CTRL_MODE_LO) | (ONE << CTRL_COMPAT));
      src_u.run_src(5);
      src_u.set_aux(1'b0, 1'b0);
      src_u.run_src(5);
      drain();
      // Sample-clocked form stores on a sample edge; an empty interval overruns
      apb(1'b1, ADDR_CTRL, ONE | (32'(MODE_SAMPLED) << CTRL_MODE_LO));
      src_u.set_levels(1'b1, 1'b0);
      src_u.run_src(2);
      src_u.set_levels(1'b1, 1'b1);
      check(dmaValid === 1'b0, "stored before sample edge");
      expQ.push_back(32'h2);
      for (int s = 0; s < 4; s++) src_u.set_aux(!s[0], 1'b0);
      drain();
      rd_chk(ADDR_STATUS, 32'h19, 1'b0);
      tally_and_finish();
   end
endmodule // esc_counter_tb_top
`default_nettype wire
